// ==== common/twi_pin_pkg.sv ====
package twi_pin_pkg;
	// ----------------------------------------------------------------
	// Serial modes
	// ----------------------------------------------------------------
	localparam logic [1:0] MODE_THREE_WIRE = 2'h0;
	localparam logic [1:0] MODE_TWO_WIRE   = 2'h1;
	localparam logic [1:0] MODE_BUS        = 2'h2;

	// ----------------------------------------------------------------
	// Bit positions inside the control bytes
	// ----------------------------------------------------------------
	localparam int CH_ENABLE_BIT   = 7;
	localparam int WAKE_BIT        = 5;
	localparam int CLK_LEVEL_BIT   = 3;
	localparam int WAIT_REL_BIT    = 2;
	localparam int RELEASE_TRG_BIT = 0;
	localparam int COMMAND_TRG_BIT = 1;

	// ----------------------------------------------------------------
	// Transfer shape and reset values
	// ----------------------------------------------------------------
	localparam logic [3:0] BITS_PER_XFER = 4'h8;
	localparam logic [3:0] BIT_CNT_ZERO  = 4'h0;
	localparam logic [7:0] ADDR_RESET    = 8'h00;
	localparam logic [7:0] SHIFT_RESET   = 8'h00;

	typedef enum logic [1:0] {
		XFER_IDLE,
		XFER_SHIFT,
		XFER_DONE
	} link_state_t;
endpackage : twi_pin_pkg

// ==== rtl/twi_pin_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none

module twi_pin_ctrl (
	// System side
	input  wire logic       clk,
	input  wire logic       rst_n,
	// Link clock (bus clock as seen by the shifter)
	input  wire logic       link_clk,
	// Channel configuration
	input  wire logic [1:0] serial_mode_reg_ch0,
	input  wire logic       channel_enable_bit,
	input  wire logic       wake_on_address_match,
	input  wire logic [7:0] slave_address,
	// Port latches and directions
	input  wire logic       clock_port_bit,
	input  wire logic       data_port_bit,
	input  wire logic       clock_port_direction,
	input  wire logic       data_port_direction,
	// Control strobes (one-cycle pulses)
	input  wire logic       clock_level_control,
	input  wire logic       wait_release_bit,
	input  wire logic       data_release_trigger,
	input  wire logic       command_trigger,
	input  wire logic       shift_write,
	input  wire logic [7:0] shift_wdata,
	input  wire logic       done_clear,
	// Pins: out, enable (low while driving), in
	input  wire logic       serial_clock_pin_in,
	output logic            serial_clock_pin_out,
	output logic            serial_clock_pin_oe_n,
	input  wire logic       bus_data_pin_a_in,
	output logic            bus_data_pin_a_out,
	output logic            bus_data_pin_a_oe_n,
	// Status
	output logic [7:0]      shift_reg_ch0,
	output logic            transfer_done_flag,
	output logic            transfer_status,
	output logic            address_match,
	output logic            clock_level_detect,
	output logic            slave_wait
);

	// ----------------------------------------------------------------
	// Input synchronisers for pin levels
	// ----------------------------------------------------------------
	logic scl_meta;
	logic scl_sync;
	logic sda_meta;
	logic sda_sync;

	// Two stages per pin; the shifter samples the data pin unsynchronised
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_meta <= 1'b1;
			scl_sync <= 1'b1;
			sda_meta <= 1'b1;
			sda_sync <= 1'b1;
		end else begin
			scl_meta <= serial_clock_pin_in;
			scl_sync <= scl_meta;
			sda_meta <= bus_data_pin_a_in;
			sda_sync <= sda_meta;
		end
	end

	// ----------------------------------------------------------------
	// Mode decode
	// ----------------------------------------------------------------
	logic bus_mode;
	assign bus_mode = (serial_mode_reg_ch0 == twi_pin_pkg::MODE_BUS);

	// ----------------------------------------------------------------
	// Start request: system to link, toggle crossing
	// ----------------------------------------------------------------
	logic       start_tgl;
	logic [7:0] start_data;
	logic       wait_hold;

	// A write also ends a slave wait; refused while wake-up runs
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			start_tgl  <= 1'b0;
			start_data <= twi_pin_pkg::SHIFT_RESET;
		end else if (shift_write && channel_enable_bit &&
			!wake_on_address_match) begin
			start_tgl  <= ~start_tgl;
			start_data <= shift_wdata;
		end
	end

	// ----------------------------------------------------------------
	// Link domain: byte shifter on the bus clock
	// ----------------------------------------------------------------
	logic                    ls_start_meta;
	logic                    ls_start_sync;
	logic                    ls_start_seen;
	logic                    ls_en_meta;
	logic                    ls_en;
	logic                    ls_wake_meta;
	logic                    ls_wake;
	twi_pin_pkg::link_state_t lstate;
	logic [3:0]              lcount;
	logic [7:0]              lshift;
	logic                    ldone_tgl;

	// Level and event crossings into the link domain
	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			ls_start_meta <= 1'b0;
			ls_start_sync <= 1'b0;
			ls_en_meta    <= 1'b0;
			ls_en         <= 1'b0;
			ls_wake_meta  <= 1'b0;
			ls_wake       <= 1'b0;
		end else begin
			ls_start_meta <= start_tgl;
			ls_start_sync <= ls_start_meta;
			ls_en_meta    <= channel_enable_bit;
			ls_en         <= ls_en_meta;
			ls_wake_meta  <= wake_on_address_match;
			ls_wake       <= ls_wake_meta;
		end
	end

	// Shifter; with wake-up it receives without a shift write
	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			lstate        <= twi_pin_pkg::XFER_IDLE;
			lcount        <= twi_pin_pkg::BIT_CNT_ZERO;
			lshift        <= twi_pin_pkg::SHIFT_RESET;
			ldone_tgl     <= 1'b0;
			ls_start_seen <= 1'b0;
		end else begin
			ls_start_seen <= ls_start_sync;
			case (lstate)
				twi_pin_pkg::XFER_IDLE: begin
					if (ls_en && (ls_start_sync != ls_start_seen)) begin
						lstate <= twi_pin_pkg::XFER_SHIFT;
						lshift <= start_data;
						lcount <= twi_pin_pkg::BIT_CNT_ZERO;
					end else if (ls_en && ls_wake) begin
						lstate <= twi_pin_pkg::XFER_SHIFT;
						lcount <= twi_pin_pkg::BIT_CNT_ZERO;
					end
				end
				twi_pin_pkg::XFER_SHIFT: begin
					// MSB first, line sampled into the low bit
					lshift <= {lshift[6:0], bus_data_pin_a_in};
					lcount <= lcount + 4'h1;
					if (!ls_en) begin
						lstate <= twi_pin_pkg::XFER_IDLE;
					end else if (lcount == twi_pin_pkg::BITS_PER_XFER
						- 4'h1) begin
						lstate <= twi_pin_pkg::XFER_DONE;
					end
				end
				default: begin
					ldone_tgl <= ~ldone_tgl;
					lstate    <= twi_pin_pkg::XFER_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Completion back into the system domain
	// ----------------------------------------------------------------
	logic done_meta;
	logic done_sync;
	logic done_seen;
	logic done_evt;
	logic was_written;
	logic in_shift;

	assign done_evt = (done_sync != done_seen);

	// Toggle crossing; the captured byte is stable once toggled
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			done_meta <= 1'b0;
			done_sync <= 1'b0;
			done_seen <= 1'b0;
		end else begin
			done_meta <= ldone_tgl;
			done_sync <= done_meta;
			done_seen <= done_sync;
		end
	end

	// Busy marks a byte started by a shift write (not a wake-up receive), for clock idling
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			in_shift <= 1'b0;
		end else if (!channel_enable_bit || done_evt) begin
			in_shift <= 1'b0;
		end else if (shift_write && !wake_on_address_match) begin
			in_shift <= 1'b1;
		end
	end

	// Remember that a shift write has come since the channel was last enabled
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			was_written <= 1'b0;
		end else if (!channel_enable_bit) begin
			was_written <= 1'b0;
		end else if (shift_write && !wake_on_address_match) begin
			was_written <= 1'b1;
		end
	end

	// Done flag: set wins over a same-cycle clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			transfer_done_flag <= 1'b0;
			shift_reg_ch0      <= twi_pin_pkg::SHIFT_RESET;
		end else if (done_evt) begin
			transfer_done_flag <= 1'b1;
			shift_reg_ch0      <= lshift;
		end else if (done_clear) begin
			transfer_done_flag <= 1'b0;
		end
	end

	// Transfer status: only a channel stop releases it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			transfer_status <= 1'b0;
		end else if (!channel_enable_bit) begin
			transfer_status <= 1'b0;
		end else if (done_evt && was_written) begin
			transfer_status <= 1'b1;
		end
	end

	// Address compare; in transfer status every received byte is compared too,
	// which is the hazard software must avoid
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			address_match <= 1'b0;
		end else if (!wake_on_address_match || !channel_enable_bit) begin
			address_match <= 1'b0;
		end else if (done_evt && (transfer_status || !was_written)) begin
			address_match <= (lshift == slave_address);
		end
	end

	// ----------------------------------------------------------------
	// Slave wait after each byte in bus mode
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wait_hold <= 1'b0;
		end else if (done_evt && bus_mode) begin
			wait_hold <= 1'b1;
		end else if (wait_release_bit || shift_write ||
			!channel_enable_bit) begin
			wait_hold <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Data line control bits
	// ----------------------------------------------------------------
	logic data_out_latch;

	// Release trigger lets go of the line, command trigger pulls it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			data_out_latch <= 1'b1;
		end else if (data_release_trigger) begin
			data_out_latch <= 1'b1;
		end else if (command_trigger) begin
			data_out_latch <= 1'b0;
		end else if (done_evt) begin
			data_out_latch <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Clock and data pin drive
	// ----------------------------------------------------------------
	logic int_sclk;
	logic clk_level;
	logic next_scl_out;
	logic next_scl_oe_n;
	logic next_sda_out;
	logic next_sda_oe_n;

	// Clock-level bit held between strobes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			clk_level <= 1'b1;
		end else if (clock_level_control) begin
			clk_level <= ~clk_level;
		end
	end

	// Idle serial clock: one in wire modes, zero in bus mode
	assign int_sclk = bus_mode ? (in_shift && !clk_level) : 1'b1;

	always_comb begin
		next_scl_out  = 1'b0;
		next_scl_oe_n = 1'b1;
		next_sda_out  = 1'b0;
		next_sda_oe_n = 1'b1;
		if (clock_port_direction) begin
			// Pins in input mode: released
			next_scl_oe_n = 1'b1;
		end else if (!channel_enable_bit && bus_mode) begin
			next_scl_out  = 1'b1;
			next_scl_oe_n = 1'b0;
		end else if (bus_mode) begin
			// Open drain low on any of the three terms
			next_scl_oe_n = (in_shift && !int_sclk) ? 1'b0 :
				(!clk_level || !clock_port_bit) ? 1'b0 : 1'b1;
		end else begin
			next_scl_out  = clock_port_bit & int_sclk;
			next_scl_oe_n = 1'b0;
		end
		if (data_port_direction) begin
			next_sda_oe_n = 1'b1;
		end else if (!channel_enable_bit && bus_mode) begin
			next_sda_oe_n = 1'b0;
		end else if (bus_mode) begin
			// Latch at one keeps the line released
			next_sda_oe_n = data_port_bit | data_out_latch;
		end else begin
			next_sda_out  = data_out_latch;
			next_sda_oe_n = 1'b0;
		end
	end

	// Registered pin outputs and status
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			serial_clock_pin_out  <= 1'b0;
			serial_clock_pin_oe_n <= 1'b1;
			bus_data_pin_a_out    <= 1'b0;
			bus_data_pin_a_oe_n   <= 1'b1;
			clock_level_detect    <= 1'b1;
			slave_wait            <= 1'b0;
		end else begin
			serial_clock_pin_out  <= next_scl_out;
			serial_clock_pin_oe_n <= next_scl_oe_n;
			bus_data_pin_a_out    <= next_sda_out;
			bus_data_pin_a_oe_n   <= next_sda_oe_n;
			clock_level_detect    <= scl_sync;
			slave_wait            <= wait_hold;
		end
	end

endmodule : twi_pin_ctrl

`default_nettype wire

// ==== verif/twi_pin_ctrl_sva.sv ====
`timescale 1ns/1ps
`default_nettype none

module twi_pin_ctrl_sva (
	// System side
	input wire logic       clk,
	input wire logic       rst_n,
	// Configuration
	input wire logic [1:0] serial_mode_reg_ch0,
	input wire logic       channel_enable_bit,
	input wire logic       wake_on_address_match,
	input wire logic       clock_port_bit,
	input wire logic       data_port_bit,
	input wire logic       clock_port_direction,
	input wire logic       data_port_direction,
	input wire logic       wait_release_bit,
	input wire logic       done_clear,
	// Pins and status
	input wire logic       serial_clock_pin_in,
	input wire logic       serial_clock_pin_out,
	input wire logic       serial_clock_pin_oe_n,
	input wire logic       bus_data_pin_a_out,
	input wire logic       bus_data_pin_a_oe_n,
	input wire logic       transfer_done_flag,
	input wire logic       transfer_status,
	input wire logic       clock_level_detect,
	input wire logic       slave_wait
);
	logic bus;
	logic en;

	// Short names; settle counts allow for registered pins
	assign bus = serial_mode_reg_ch0 == twi_pin_pkg::MODE_BUS;
	assign en  = channel_enable_bit;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	a_done_holds: assert property (transfer_done_flag && !done_clear |=> transfer_done_flag)
		else $error("done flag dropped without clear");
	a_status_holds: assert property (transfer_status && en |=> transfer_status)
		else $error("transfer status lost while enabled");
	a_status_drops: assert property (!en [*3] |-> !transfer_status)
		else $error("transfer status kept while stopped");
	a_stop_pins: assert property ((bus && !en && clock_port_bit && !data_port_bit && !clock_port_direction && !data_port_direction) [*3] |-> (serial_clock_pin_oe_n || serial_clock_pin_out) && !bus_data_pin_a_oe_n && !bus_data_pin_a_out)
		else $error("stopped pins wrong");
	a_input_release: assert property ((!en && clock_port_direction && data_port_direction) [*3] |-> serial_clock_pin_oe_n && bus_data_pin_a_oe_n)
		else $error("input pins driven");
	a_latch_low: assert property ((bus && en && !clock_port_bit && !clock_port_direction) [*3] |-> !serial_clock_pin_oe_n && !serial_clock_pin_out)
		else $error("clock not low with latch zero");
	a_clock_od: assert property ((bus && en) [*3] ##0 !serial_clock_pin_oe_n |-> !serial_clock_pin_out)
		else $error("clock driven high");
	a_data_release: assert property ((bus && en && data_port_bit) [*3] |-> bus_data_pin_a_oe_n || bus_data_pin_a_out)
		else $error("data pulled low with latch one");
	a_detect_follow: assert property ($stable(serial_clock_pin_in) [*4] |-> clock_level_detect == serial_clock_pin_in)
		else $error("clock detect does not follow line");
	a_wait_release: assert property (slave_wait && wait_release_bit |-> ##[1:3] !slave_wait)
		else $error("wait not released");
	a_done_status: assert property ($rose(transfer_done_flag) && !wake_on_address_match |-> ##[0:3] transfer_status)
		else $error("no transfer status after done");
endmodule : twi_pin_ctrl_sva

bind twi_pin_ctrl twi_pin_ctrl_sva u_sva (
	.clk(clk), .rst_n(rst_n), .serial_mode_reg_ch0(serial_mode_reg_ch0),
	.channel_enable_bit(channel_enable_bit),
	.wake_on_address_match(wake_on_address_match),
	.clock_port_bit(clock_port_bit), .data_port_bit(data_port_bit),
	.clock_port_direction(clock_port_direction),
	.data_port_direction(data_port_direction),
	.wait_release_bit(wait_release_bit), .done_clear(done_clear),
	.serial_clock_pin_in(serial_clock_pin_in),
	.serial_clock_pin_out(serial_clock_pin_out),
	.serial_clock_pin_oe_n(serial_clock_pin_oe_n),
	.bus_data_pin_a_out(bus_data_pin_a_out),
	.bus_data_pin_a_oe_n(bus_data_pin_a_oe_n),
	.transfer_done_flag(transfer_done_flag),
	.transfer_status(transfer_status),
	.clock_level_detect(clock_level_detect), .slave_wait(slave_wait));

`default_nettype wire

// ==== verif/twi_bus_master_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module twi_bus_master_model (
	// Link clock and requests from the bench
	input  wire logic link_clk,
	input  wire logic pull_data,
	input  wire logic pull_clock,
	// Device pin drive
	input  wire logic scl_out,
	input  wire logic scl_oe_n,
	input  wire logic sda_out,
	input  wire logic sda_oe_n,
	// Resolved bus lines
	output logic      scl_line,
	output logic      sda_line
);
	logic data_low  = 1'b0;
	logic clock_low = 1'b0;

	// Master changes its drive only on the link clock, as a real master
	always @(negedge link_clk) begin
		data_low  <= pull_data;
		clock_low <= pull_clock;
	end

	// Pull-ups: a released line reads high, any low driver wins
	assign scl_line = (scl_oe_n ? 1'b1 : scl_out) & ~clock_low;
	assign sda_line = (sda_oe_n ? 1'b1 : sda_out) & ~data_low;
endmodule : twi_bus_master_model

`default_nettype wire

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none

module testbench;
	logic       clk = 1'b0, link_clk = 1'b0, rst_n = 1'b1;
	logic [1:0] mode = twi_pin_pkg::MODE_THREE_WIRE;
	logic       en = 1'b0, wake = 1'b0, clat = 1'b1, dlat = 1'b0;
	logic       cdir = 1'b0, ddir = 1'b0, pull_data = 1'b0, pull_clock = 1'b0;
	logic [7:0] addr = 8'h5A;
	logic [5:0] strb = 6'h00;
	logic       scl_out, scl_oe_n, sda_out, sda_oe_n, scl_line, sda_line;
	logic [7:0] shift_reg_ch0;
	logic       transfer_done_flag, transfer_status, address_match;
	logic       clock_level_detect, slave_wait;
	int         bad_count = 0, cmp_count = 0;

	// Free clocks; link clock offset so the two never share an edge
	initial begin
		forever #2.5 clk = ~clk;
	end
	initial begin
		#13;
		forever #40 link_clk = ~link_clk;
	end

	twi_pin_ctrl u_twi_pin_ctrl (
		.clk(clk), .rst_n(rst_n), .link_clk(link_clk),
		.serial_mode_reg_ch0(mode), .channel_enable_bit(en),
		.wake_on_address_match(wake), .slave_address(addr),
		.clock_port_bit(clat), .data_port_bit(dlat),
		.clock_port_direction(cdir), .data_port_direction(ddir),
		.clock_level_control(strb[0]), .wait_release_bit(strb[1]),
		.data_release_trigger(strb[2]), .command_trigger(strb[3]),
		.shift_write(strb[4]), .shift_wdata(8'hFF), .done_clear(strb[5]),
		.serial_clock_pin_in(scl_line), .serial_clock_pin_out(scl_out),
		.serial_clock_pin_oe_n(scl_oe_n), .bus_data_pin_a_in(sda_line),
		.bus_data_pin_a_out(sda_out), .bus_data_pin_a_oe_n(sda_oe_n),
		.shift_reg_ch0(shift_reg_ch0),
		.transfer_done_flag(transfer_done_flag),
		.transfer_status(transfer_status), .address_match(address_match),
		.clock_level_detect(clock_level_detect), .slave_wait(slave_wait));

	twi_bus_master_model u_twi_bus_master_model (
		.link_clk(link_clk), .pull_data(pull_data), .pull_clock(pull_clock),
		.scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_out(sda_out),
		.sda_oe_n(sda_oe_n), .scl_line(scl_line), .sda_line(sda_line));

	// Compare and count; unknowns never match
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic check1(input logic seen, input logic exp);
		check({7'h00, seen}, {7'h00, exp});
	endtask : check1

	// One-cycle strobe, raised and lowered on falling edges
	task automatic pulse(input int i);
		@(negedge clk) strb[i] = 1'b1;
		@(negedge clk) strb[i] = 1'b0;
	endtask : pulse

	// Long enough for a link edge plus the synchroniser
	task automatic settle();
		repeat (24) @(negedge clk);
	endtask : settle

	// Bounded wait on done flag (0) or address match (1)
	task automatic wait_until(input int which);
		int n;
		n = 0;
		while ((which ? address_match : transfer_done_flag) !== 1'b1 && n < 2000) begin
			@(negedge clk);
			n++;
		end
		// A wait that runs out counts against the run
		if ((which ? address_match : transfer_done_flag) !== 1'b1) begin
			bad_count++;
			$display("mismatch at %0t: wait ran out", $time);
		end
	endtask : wait_until

	task automatic print_verdict();
		if (bad_count == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : print_verdict

	// Watchdog well beyond the expected run length
	initial begin
		#200us;
		bad_count++;
		print_verdict();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		// Reset by a real edge so the link-clock flops clear as well
		@(negedge clk) rst_n = 1'b0;
		repeat (5) @(negedge clk);
		check({6'h00, scl_oe_n, sda_oe_n}, 8'h03);
		check1(transfer_done_flag | transfer_status, 1'b0);
		rst_n = 1'b1;
		repeat (3) @(negedge clk);
		en = 1'b1;
		clat = 1'b0;
		settle();
		check1(scl_line, 1'b0);
		clat = 1'b1;
		settle();
		check1(scl_line, 1'b1);
		pull_clock = 1'b1;
		settle();
		check1(clock_level_detect, 1'b0);
		pull_clock = 1'b0;
		settle();
		check1(clock_level_detect, 1'b1);
		mode = twi_pin_pkg::MODE_BUS;
		clat = 1'b0;
		settle();
		check1(scl_line, 1'b0);
		clat = 1'b1;
		pulse(0);
		settle();
		check1(scl_line, 1'b0);
		pulse(0);
		// Back-to-back bytes: master low, released, low again
		for (int i = 0; i < 3; i++) begin
			pull_data = (i != 1);
			pulse(4);
			settle();
			if (i > 0) check1(slave_wait, 1'b0);
			wait_until(0);
			settle();
			check(shift_reg_ch0, (i == 1) ? 8'hFF : 8'h00);
			check1(transfer_status, 1'b1);
			check1(slave_wait, 1'b1);
			pulse(5);
			settle();
			check1(transfer_done_flag, 1'b0);
		end
		pulse(1);
		settle();
		check1(slave_wait, 1'b0);
		pulse(3);
		pull_data = 1'b0;
		en = 1'b0;
		settle();
		check1(transfer_status, 1'b0);
		check({6'h00, scl_line, sda_line}, 8'h02);
		// Float the pins while stopped, then restart the channel
		dlat = 1'b1;
		ddir = 1'b1;
		cdir = 1'b1;
		settle();
		check({6'h00, scl_oe_n, sda_oe_n}, 8'h03);
		en = 1'b1;
		settle();
		ddir = 1'b0;
		settle();
		check1(sda_line, 1'b1);
		pulse(2);
		cdir = 1'b0;
		dlat = 1'b0;
		settle();
		check1(sda_line, 1'b1);
		addr = 8'h00;
		wake = 1'b1;
		pull_data = 1'b1;
		wait_until(1);
		check1(address_match, 1'b1);
		print_verdict();
	end
endmodule : testbench

`default_nettype wire
